// >>> mber_top.sv
// modbus command supervisor and can error frame builder
`timescale 1ns/1ps
`include "mber_consts.svh"
module mber_top
  import mber_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = (`MBER_CLK_HZ / `MBER_MS_PER_S) * `MBER_BLINK_MS,
  parameter int unsigned TICK_DIV     = `MBER_CLK_HZ / `MBER_MS_PER_S
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire mber_cfg_t    i_cfg,
  input  wire logic         i_cmd_sent,
  input  wire logic [7:0]   i_cmd_node,
  input  wire logic [7:0]   i_cmd_func,
  input  wire logic         i_reply_valid,
  input  wire mber_reply_t  i_reply,
  output logic              o_next_cmd,
  output logic              o_frame_valid,
  input  wire logic         i_frame_ready,
  output mber_frame_t       o_frame,
  input  wire logic         i_can_fail,
  output logic              o_power_indicator,
  input  wire logic         i_status_query_command,
  output logic              o_status_valid,
  output mber_status_t      o_status
);
  // ------------------------------------------------------------
  // configuration snapshot
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_WAIT, ST_SEND} mber_state_t;
  localparam int unsigned DIV_W = $clog2(TICK_DIV);

  mber_state_t  state_ff, nxt_state;
  mber_cfg_t    cfg_ff, nxt_cfg;
  logic [7:0]   node_ff, nxt_node;
  logic [7:0]   func_ff, nxt_func;
  logic [15:0]  tmo_ff, nxt_tmo;
  logic [DIV_W-1:0] div_ff, nxt_div;
  mber_frame_t  frame_ff, nxt_frame;
  logic         next_ff, nxt_next;
  logic [7:0]   code_ff, nxt_code;
  logic [7:0]   fcnt_ff, nxt_fcnt;
  logic         stv_ff, nxt_stv;
  mber_status_t nxt_status;
  logic         tick;
  logic [28:0]  id_lim;

  // ms tick from the divider; the timeout counts whole ticks, so the
  // real wait lies between timeout and timeout+1 ms
  assign tick = (div_ff == DIV_W'(TICK_DIV - 1)); // 1 ms enable at 20 MHz

  // clamp the identifier to the chosen frame format
  // an over-range id is clamped rather than refused, so a bad setting
  // still yields a frame on a legal identifier
  always_comb begin
    id_lim = cfg_ff.id;
    if (!cfg_ff.ext && (cfg_ff.id > `MBER_STD_ID_MAX)) begin
      id_lim = `MBER_STD_ID_MAX;
    end else if (cfg_ff.id > `MBER_EXT_ID_MAX) begin
      id_lim = `MBER_EXT_ID_MAX;
    end
  end

  // ------------------------------------------------------------
  // supervision state machine
  // ------------------------------------------------------------
  // settings are captured once after reset so edits at run time
  // cannot disturb a command that is in flight
  always_comb begin
    nxt_state = state_ff;
    nxt_cfg   = cfg_ff;
    nxt_node  = node_ff;
    nxt_func  = func_ff;
    nxt_tmo   = tmo_ff;
    nxt_div   = tick ? '0 : div_ff + 1'b1;
    nxt_frame = frame_ff;
    nxt_next  = 1'b0;
    nxt_code  = code_ff;
    nxt_fcnt  = fcnt_ff;
    case (state_ff)
      ST_LOAD: begin
        // single snapshot; later edits wait for the next restart
        nxt_cfg   = i_cfg;
        nxt_state = ST_IDLE;
      end
      ST_IDLE: begin
        // node and function are captured with the strobe only
        if (i_cmd_sent) begin
          nxt_node  = i_cmd_node;
          nxt_func  = i_cmd_func;
          nxt_tmo   = '0;
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // reserved bytes stay zero, exception bytes default zero
        nxt_frame.ext  = cfg_ff.ext;
        nxt_frame.id   = id_lim;
        nxt_frame.dlc  = `MBER_DLC;
        nxt_frame.data = '0;
        if (i_reply_valid) begin
          if (i_reply.node != node_ff) begin
            nxt_code  = `MBER_CODE_NODE;
          end else if (i_reply.func == (func_ff | `MBER_EXC_BIT)) begin
            // only an echo of our own function with the top bit set counts;
            // any other reply from the right node is a normal answer
            nxt_code  = `MBER_CODE_EXCEPT;
            nxt_frame.data[8*`MBER_BYTE_NODE +: 8] = i_reply.node;
            nxt_frame.data[8*`MBER_BYTE_FUNC +: 8] = i_reply.func;
            nxt_frame.data[8*`MBER_BYTE_EXC +: 8]  = i_reply.code;
          end else begin
            nxt_code  = `MBER_CODE_NONE;
          end
          nxt_frame.data[8*`MBER_BYTE_CODE +: 8] = nxt_code;
          if (cfg_ff.err_en && nxt_code != `MBER_CODE_NONE) begin
            nxt_fcnt  = fcnt_ff + 1'b1;
            nxt_state = ST_SEND;
          end else begin
            nxt_next  = 1'b1;
            nxt_state = ST_IDLE;
          end
        end else if (tick) begin
          // timeouts are counted even with reporting off, so a status
          // query still shows that the slave went quiet
          if (tmo_ff >= cfg_ff.timeout) begin
            nxt_code = `MBER_CODE_TIMEOUT;
            nxt_frame.data[8*`MBER_BYTE_CODE +: 8] = `MBER_CODE_TIMEOUT;
            nxt_fcnt = fcnt_ff + 1'b1;
            if (cfg_ff.err_en) begin
              nxt_state = ST_SEND;
            end else begin
              nxt_next  = 1'b1;
              nxt_state = ST_IDLE;
            end
          end else begin
            nxt_tmo = tmo_ff + 1'b1;
          end
        end
      end
      ST_SEND: begin
        // the frame stays offered until taken, so one frame per failure
        if (i_frame_ready) begin
          nxt_next  = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_LOAD;
    endcase
  end

  // registers only; every next value comes from the block above
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_LOAD;
      cfg_ff   <= '0;
      node_ff  <= '0;
      func_ff  <= '0;
      tmo_ff   <= '0;
      div_ff   <= '0;
      frame_ff <= '0;
      next_ff  <= 1'b0;
      code_ff  <= `MBER_CODE_NONE;
      fcnt_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      cfg_ff   <= nxt_cfg;
      node_ff  <= nxt_node;
      func_ff  <= nxt_func;
      tmo_ff   <= nxt_tmo;
      div_ff   <= nxt_div;
      frame_ff <= nxt_frame;
      next_ff  <= nxt_next;
      code_ff  <= nxt_code;
      fcnt_ff  <= nxt_fcnt;
    end
  end

  // ------------------------------------------------------------
  // status query answer
  // ------------------------------------------------------------
  // the snapshot is refreshed every cycle, so the answer to a query
  // reflects the cycle in which the query arrived
  always_comb begin
    nxt_stv               = i_status_query_command;
    nxt_status            = '0;
    nxt_status.busy       = (state_ff != ST_IDLE);
    nxt_status.can_fail   = i_can_fail;
    nxt_status.last_code  = code_ff;
    nxt_status.fail_count = fcnt_ff;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stv_ff   <= 1'b0;
      o_status <= '0;
    end else begin
      stv_ff   <= nxt_stv;
      o_status <= nxt_status;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // frame valid is decoded from the state so it falls in the cycle
  // after the handshake; the frame itself comes from a register
  assign o_status_valid = stv_ff;
  assign o_frame_valid  = (state_ff == ST_SEND);
  assign o_frame        = frame_ff;
  assign o_next_cmd     = next_ff;

  // ------------------------------------------------------------
  // power indicator
  // ------------------------------------------------------------
  // the period is a parameter so a bench can shorten it
  mber_blink #(
    .CYCLES (BLINK_CYCLES)
  ) mber_blink_inst (
    .i_ref_clk         (i_ref_clk),
    .i_rst_n           (i_rst_n),
    .i_can_fail        (i_can_fail),
    .o_power_indicator (o_power_indicator)
  );
endmodule : mber_top

// >>> mber_consts.svh
// constants for the modbus error response framer
`ifndef MBER_CONSTS_SVH
`define MBER_CONSTS_SVH
`define MBER_DLC            4'h8
`define MBER_CODE_NONE      8'h00
`define MBER_CODE_NODE      8'h01
`define MBER_CODE_TIMEOUT   8'h02
`define MBER_CODE_EXCEPT    8'h03
`define MBER_EXC_BIT        8'h80
`define MBER_BYTE_CODE      0
`define MBER_BYTE_NODE      4
`define MBER_BYTE_FUNC      5
`define MBER_BYTE_EXC       6
`define MBER_STD_ID_MAX     29'h00007ff
`define MBER_EXT_ID_MAX     29'h1fffffff
`define MBER_CLK_HZ         20000000
`define MBER_BLINK_MS       100
`define MBER_MS_PER_S       1000
`endif

// >>> mber_pkg.sv
// types for the modbus error response framer
package mber_pkg;
  typedef struct packed {
    logic        ext;
    logic [28:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } mber_frame_t;

  typedef struct packed {
    logic [7:0] node;
    logic [7:0] func;
    logic [7:0] code;
  } mber_reply_t;

  typedef struct packed {
    logic       err_en;
    logic       ext;
    logic [28:0] id;
    logic [15:0] timeout;
  } mber_cfg_t;

  typedef struct packed {
    logic       busy;
    logic       can_fail;
    logic [7:0] last_code;
    logic [7:0] fail_count;
  } mber_status_t;
endpackage : mber_pkg

// >>> mber_blink.sv
// power indicator blinker, toggles each 100ms while can is stuck
`timescale 1ns/1ps
`include "mber_consts.svh"
module mber_blink
  import mber_pkg::*;
#(
  parameter int unsigned CYCLES = (`MBER_CLK_HZ / `MBER_MS_PER_S) * `MBER_BLINK_MS
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_can_fail,
  output logic      o_power_indicator
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          led_ff;
  logic          nxt_led;

  // steady on when healthy; one toggle per period when stuck
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_led = led_ff;
    if (!i_can_fail) begin
      nxt_cnt = '0;
      nxt_led = 1'b1;
    end else if (cnt_ff == CW'(CYCLES - 1)) begin
      nxt_cnt = '0;
      nxt_led = ~led_ff;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
      led_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      led_ff <= nxt_led;
    end
  end

  assign o_power_indicator = led_ff;
endmodule : mber_blink

// >>> mber_properties.sv
// checker for the error frame, handshake, status and indicator ports
`timescale 1ns/1ps
module mber_properties
  import mber_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic        o_frame_valid,
  input wire logic        i_frame_ready,
  input wire mber_frame_t o_frame,
  input wire logic        o_next_cmd,
  input wire logic        i_status_query_command,
  input wire logic        o_status_valid,
  input wire logic        i_can_fail,
  input wire logic        o_power_indicator
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // frame layout while offered
  property p_len; o_frame_valid |-> o_frame.dlc == 4'h8; endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_rsv; o_frame_valid |-> o_frame.data[31:8] == 24'h0 && o_frame.data[63:56] == 8'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved byte set");
  property p_exz; o_frame_valid && o_frame.data[7:0] != 8'h03 |-> o_frame.data[63:32] == 32'h0; endproperty
  a_exz: assert property (p_exz) else $error("detail bytes set");
  property p_std; o_frame_valid && !o_frame.ext |-> o_frame.id <= 29'h7ff; endproperty
  a_std: assert property (p_std) else $error("id over range");
  // handshake, status and indicator timing
  property p_hold; o_frame_valid && !i_frame_ready |=> o_frame_valid && $stable(o_frame); endproperty
  a_hold: assert property (p_hold) else $error("frame dropped");
  property p_next; o_frame_valid && i_frame_ready |=> o_next_cmd && !o_frame_valid; endproperty
  a_next: assert property (p_next) else $error("no next command");
  property p_stat; i_status_query_command |=> o_status_valid; endproperty
  a_stat: assert property (p_stat) else $error("no status answer");
  property p_led; !i_can_fail [*3] |-> o_power_indicator; endproperty
  a_led: assert property (p_led) else $error("indicator not steady");
  c_exc: cover property (o_frame_valid && o_frame.data[7:0] == 8'h03);
  c_next: cover property (o_next_cmd);
  c_blink: cover property ($fell(o_power_indicator));
endmodule : mber_properties

bind mber_top mber_properties mber_properties_inst (.i_ref_clk, .i_rst_n, .o_frame_valid, .i_frame_ready,
  .o_frame, .o_next_cmd, .i_status_query_command, .o_status_valid, .i_can_fail, .o_power_indicator);

// >>> mber_slave_model.sv
// modbus slave and can node on the framer's far side
`timescale 1ns/1ps
module mber_slave_model
  import mber_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_cmd_sent,
  input  wire logic [7:0] i_node,
  input  wire logic [7:0] i_func,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_frame_valid,
  output logic            o_reply_valid = 1'b0,
  output mber_reply_t     o_reply       = '0,
  output logic            o_frame_ready = 1'b0
);
  // peer bit timing kept at the recommended corner:
  // smallest resync jump width and second phase segment
  localparam int RESYNC_JUMP_WIDTH    = 1;
  localparam int SECOND_PHASE_SEGMENT = 1;
  localparam int ACK_STALL            = RESYNC_JUMP_WIDTH + SECOND_PHASE_SEGMENT;
  int          dly  = 0;
  int          hold = 0;
  logic        v;
  mber_reply_t r;
  // mode 0 good, 1 wrong node, 2 silent, 3 exception; idle reply bus toggles so it never looks valid
  always @(posedge i_ref_clk) begin
    v = 1'b0;
    r = ~o_reply;
    if (i_cmd_sent) dly = 3;
    else if (dly > 0) begin
      dly--;
      if (dly == 0 && i_mode != 2'd2) begin
        v = 1'b1;
        r = '{i_mode == 2'd1 ? i_node + 8'h01 : i_node, i_mode == 2'd3 ? i_func | 8'h80 : i_func, 8'h02};
      end
    end
    // can node stalls two cycles before it takes a frame
    hold = (i_frame_valid && !o_frame_ready) ? hold + 1 : 0;
    o_reply_valid <= #1 v;
    o_reply       <= #1 r;
    o_frame_ready <= #1 (hold >= ACK_STALL);
  end
endmodule : mber_slave_model

// >>> mber_top_tb_top.sv
// self-checking bench for the modbus error response framer
`timescale 1ns/1ps
module mber_top_tb_top;
  import mber_pkg::*;
  logic         clk = 0, rst_n = 0, sent = 0, cf = 0, q = 0, rdy, rv, nxt, fv, sv, led;
  logic [1:0]   mode = 0;
  logic [7:0]   node = 8'h11, func = 0;
  mber_cfg_t    cfg = '{1'b1, 1'b0, 29'h123, 16'h2};
  mber_reply_t  rep;
  mber_frame_t  fr;
  mber_status_t st;
  // rows: mode, function, expected code (0 means no frame)
  logic [17:0]  rows [11] = '{18'h10301, 18'h20602, 18'h00500, 18'h30103, 18'h30203, 18'h30303,
                               18'h30403, 18'h30503, 18'h30603, 18'h30f03, 18'h31003};
  int           n_fail = 0, check_count = 0, k;
  always #25 clk = ~clk;
  // short blink and tick counts keep the run brief
  mber_top #(.BLINK_CYCLES(8), .TICK_DIV(4)) mber_top_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cfg(cfg),
    .i_cmd_sent(sent), .i_cmd_node(node), .i_cmd_func(func), .i_reply_valid(rv), .i_reply(rep),
    .o_next_cmd(nxt), .o_frame_valid(fv), .i_frame_ready(rdy), .o_frame(fr), .i_can_fail(cf),
    .o_power_indicator(led), .i_status_query_command(q), .o_status_valid(sv), .o_status(st));
  mber_slave_model mber_slave_model_inst (.i_ref_clk(clk), .i_cmd_sent(sent), .i_node(node), .i_func(func),
    .i_mode(mode), .i_frame_valid(fv), .o_reply_valid(rv), .o_reply(rep), .o_frame_ready(rdy));
  task automatic chk(input string s, input logic [97:0] e, input logic [97:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // config is only taken at restart, so a setting that must take effect goes with a reset
  task automatic rst(input mber_cfg_t c);
    rst_n = 0;
    cfg = c;
    step(5);
    rst_n = 1;
    step(2);
  endtask : rst
  // one command; the whole frame is predicted from the expected code, function, node and id
  task automatic run(input logic [17:0] r, input logic [28:0] id);
    logic [7:0]  c;
    logic [97:0] e;
    c = r[7:0];
    mode = r[17:16];
    func = r[15:8];
    sent = 1;
    step(1);
    sent = 0;
    for (k = 0; k < 60 && !fv && !nxt; k++) step(1);
    chk("frame_valid", c != 8'h0, fv);
    // exception detail bytes: node, echoed function with top bit, code 02
    e = {cfg.ext, id, 4'h8, c == 8'h3 ? {8'h0, 8'h02, func | 8'h80, node} : 32'h0, 24'h0, c};
    if (c != 8'h0) chk("frame", e, fr);
    for (k = 0; k < 20 && !nxt; k++) step(1);
    chk("next_cmd", 1'b1, nxt);
  endtask : run
  initial begin
    rst(cfg);
    chk("idle outputs", 3'b001, {fv, nxt, led});
    for (int i = 0; i < 11; i++) run(rows[i], 29'h123);
    cfg.err_en = 1'b0;
    run(18'h10301, 29'h123);
    rst('{1'b0, 1'b0, 29'h123, 16'h2});
    run(18'h20600, 29'h123);
    rst('{1'b1, 1'b0, 29'h800, 16'h2});
    run(18'h10301, 29'h7ff);
    q = 1;
    step(1);
    q = 0;
    chk("status_valid", 1'b1, sv);
    // one wrong-node failure since the last reset, now idle
    chk("status", {1'b0, 1'b0, 8'h01, 8'h01}, st);
    cf = 1;
    for (k = 0; k < 30 && led; k++) step(1);
    for (k = 0; k < 30 && !led; k++) step(1);
    chk("blink gap", 8, k);
    // release the fault while the indicator is dark so recovery shows
    for (k = 0; k < 30 && led; k++) step(1);
    cf = 0;
    step(3);
    chk("led steady", 1'b1, led);
    stop_test();
  end
  // watchdog well beyond the expected run length
  initial begin
    #(4000 * 50);
    n_fail++;
    stop_test();
  end
endmodule : mber_top_tb_top
